// ===== rtl/fdc_param_pkg.sv
// Constants, types and register map of the command parameter decoder.
// Assumes a 250 MHz APB clock and 32-bit data.
package fdc_param_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam int STEP_UNIT_NS = 500_000;
   localparam int STEP_UNIT_CYCLES = STEP_UNIT_NS / CLK_PERIOD_NS;
   localparam int STEP_UNITS_MAX = 16;
   localparam int POLL_PERIOD_NS = 1_000_000;
   localparam int POLL_CYCLES = POLL_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [14:0] BASE_SECTOR_BYTES = 15'h0080;
   localparam logic [7:0] MAX_SIZE_CODE = 8'h07;

   localparam logic [11:0] OFS_MODE = 12'h000;
   localparam logic [11:0] OFS_SECTOR = 12'h004;
   localparam logic [11:0] OFS_TRACK = 12'h008;
   localparam logic [11:0] OFS_CONFIG = 12'h00c;
   localparam logic [11:0] OFS_SPECIFY = 12'h010;
   localparam logic [11:0] OFS_PERP = 12'h014;
   localparam logic [11:0] OFS_COMMAND = 12'h018;
   localparam logic [11:0] OFS_STATUS = 12'h01c;
   localparam logic [11:0] OFS_RESULT = 12'h020;
   localparam logic [11:0] OFS_LENGTH = 12'h024;

   // MODE fields
   localparam int MODE_DD = 0;
   localparam int MODE_MT = 1;
   localparam int MODE_SKIP = 2;
   localparam int MODE_ND = 3;
   localparam int MODE_EC = 4;
   localparam int MODE_HEAD = 5;
   // TRACK and CONFIG fields
   localparam int TRACK_DIR = 16;
   localparam int CFG_FIFO_N = 4;
   localparam int CFG_POLL_OFF = 5;
   localparam int CFG_LOCK = 6;
   // PERP and COMMAND fields
   localparam int PERP_WRITE_GATE_TIMING = 1;
   localparam int PERP_OW = 7;
   localparam int CMD_GO = 3;
   localparam int CMD_RESET = 8;

   localparam logic FIFO_N_RST = 1'b1;
   localparam logic [3:0] FIFO_THR_RST = 4'h0;
   localparam logic [7:0] PRECOMP_RST = 8'h00;

   typedef enum logic [2:0] {
      OP_READ = 3'b000,
      OP_READ_DEL = 3'b001,
      OP_WRITE = 3'b010,
      OP_FORMAT = 3'b011,
      OP_VERIFY = 3'b100,
      OP_SEEK = 3'b101,
      OP_REL_SEEK = 3'b110,
      OP_SENSE = 3'b111
   } op_e;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_STEP = 3'b001,
      S_SECT = 3'b010,
      S_BYTE = 3'b011,
      S_NEXT = 3'b100,
      S_DONE = 3'b101
   } state_e;

   typedef struct packed {
      logic step_pulse;
      logic step_dir;
      logic write_enable;
      logic precomp_on;
      logic encode_mfm;
      logic head_sel;
   } drive_s;
endpackage : fdc_param_pkg

// ===== rtl/floppy_command_parameter_decode.sv
// Command parameter decoder and execution engine of a floppy controller.
// Registers sit on an APB slave with no wait states; drive pins on pclk.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Function
// - With lock set, soft reset keeps FIFO enable, threshold and precomp track.
// - Density parameter one records double density, zero single density.
// - Multi-track continues from last sector of head 0 to head 1.
// - Nonzero size code gives 128 times two to the code bytes, up to 07.
// - Size code zero uses 128-byte sector, short length sets bytes passed.
// - Non-DMA flag one interrupts per byte, zero uses DMA requests.
// - Low four perpendicular bits change only when overwrite enable is one.
// - Polling routine stops while polling disable is set.
// - Precompensation starts at programmable track 00 through FFH.
// - Sector address is the first sector of a multi-sector transfer.
// - Relative seek offset is applied to the current cylinder.
// - Sectors per track counts format, and verify with count enable.
// - Bypass skips deleted sectors on read, non-deleted on read deleted.
// - Step pulses spaced 0.5 to 8 ms in 0.5 ms steps.
// - Four result status registers updated after each command.
// - Write gate parameter moves write enable earlier for pre-erase.
// - Present cylinder is reported when sense interrupt status completes.
// - Seek steps the head until it reaches the target cylinder.
// - Short sectors: reads drop excess bytes, writes pad with zeros.
// - FIFO enable bit is active low, default one leaves FIFO off.
// - Relative seek direction zero steps outward, one inward.
module floppy_command_parameter_decode #(
   parameter int STEP_UNIT = fdc_param_pkg::STEP_UNIT_CYCLES,
   parameter int POLL_PERIOD = fdc_param_pkg::POLL_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sector_deleted,
   input wire logic xfer_ack,
   input wire logic [7:0] disk_rd_data,
   input wire logic [7:0] host_wr_data,
   output logic host_irq,
   output logic dma_req,
   output logic [7:0] host_rd_data,
   output logic [7:0] disk_wr_data,
   output fdc_param_pkg::drive_s drive,
   output logic fifo_on,
   output logic [3:0] fifo_threshold_out,
   output logic poll_strobe
);
   import fdc_param_pkg::*;

   function automatic logic param_reg(input logic [11:0] a);
      return a == OFS_MODE || a == OFS_SECTOR || a == OFS_TRACK ||
             a == OFS_CONFIG || a == OFS_SPECIFY || a == OFS_PERP;
   endfunction : param_reg

   function automatic logic mapped(input logic [11:0] a);
      return param_reg(a) || a == OFS_COMMAND || a == OFS_STATUS ||
             a == OFS_RESULT || a == OFS_LENGTH;
   endfunction : mapped

   logic [1:0] del_sync;
   logic deleted_mark;
   state_e state;
   op_e op;
   logic [6:0] mode;
   logic [7:0] sector_addr;
   logic [2:0] size_code;
   logic [7:0] end_sector;
   logic [7:0] short_sector_length;
   logic [7:0] target_cylinder;
   logic [7:0] relative_cylinder_offset;
   logic rel_dir;
   logic [7:0] sectors_per_track;
   logic [3:0] fifo_threshold;
   logic fifo_enable_n;
   logic poll_disable;
   logic lock;
   logic [7:0] precomp_start_track;
   logic [3:0] step_rate_interval;
   logic [3:0] perp_bits;
   logic [7:0] result_status_0;
   logic [7:0] result_status_1;
   logic [7:0] result_status_2;
   logic [7:0] result_status_3;
   logic [7:0] present_cylinder;
   logic [7:0] head_cyl;
   logic [7:0] seek_tgt;
   logic [7:0] cur_sector;
   logic cur_head;
   logic [7:0] sect_left;
   logic [14:0] byte_cnt;
   logic [31:0] step_wait;
   logic [31:0] poll_cnt;
   logic done;
   logic access;
   logic busy;
   logic refused;
   logic wr_ok;
   logic go;
   logic soft_rst;
   logic [14:0] sector_bytes;
   logic [14:0] pass_bytes;
   logic is_read;
   logic is_write;
   logic passing;
   logic req;
   logic count_mode;
   logic last_sector;
   logic [31:0] read_word;

   // Drive pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         del_sync <= 2'b00;
      end else begin
         del_sync <= {del_sync[0], sector_deleted};
      end
   end
   assign deleted_mark = del_sync[1];

   assign access = psel & penable;
   assign busy = state != S_IDLE;
   assign pready = 1'b1;
   assign refused = !mapped(paddr) ||
      (pwrite && busy && param_reg(paddr)) ||
      (pwrite && paddr == OFS_SECTOR && pwdata[15:8] > MAX_SIZE_CODE) ||
      (pwrite && busy && paddr == OFS_COMMAND && pwdata[CMD_GO]);
   assign pslverr = access & refused;
   assign wr_ok = access & pwrite & ~refused;
   assign soft_rst = wr_ok && paddr == OFS_COMMAND && pwdata[CMD_RESET];
   assign go = wr_ok && paddr == OFS_COMMAND && pwdata[CMD_GO] && !soft_rst;

   // Command parameters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= 7'h00;
         sector_addr <= 8'h01;
         size_code <= 3'h2;
         end_sector <= 8'h01;
         short_sector_length <= 8'hff;
         target_cylinder <= 8'h00;
         relative_cylinder_offset <= 8'h00;
         rel_dir <= 1'b0;
         sectors_per_track <= 8'h01;
         step_rate_interval <= 4'h0;
      end else if (wr_ok) begin
         if (paddr == OFS_MODE) begin
            mode <= pwdata[6:0];
         end
         if (paddr == OFS_SECTOR) begin
            sector_addr <= pwdata[7:0];
            size_code <= pwdata[10:8];
            end_sector <= pwdata[23:16];
            short_sector_length <= pwdata[31:24];
         end
         if (paddr == OFS_TRACK) begin
            target_cylinder <= pwdata[7:0];
            relative_cylinder_offset <= pwdata[15:8];
            rel_dir <= pwdata[TRACK_DIR];
            sectors_per_track <= pwdata[31:24];
         end
         if (paddr == OFS_SPECIFY) begin
            step_rate_interval <= pwdata[3:0];
         end
      end
   end

   // Configuration survives a soft reset while locked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_enable_n <= FIFO_N_RST;
         fifo_threshold <= FIFO_THR_RST;
         precomp_start_track <= PRECOMP_RST;
         poll_disable <= 1'b0;
         lock <= 1'b0;
      end else if (soft_rst && !lock) begin
         fifo_enable_n <= FIFO_N_RST;
         fifo_threshold <= FIFO_THR_RST;
         precomp_start_track <= PRECOMP_RST;
      end else if (wr_ok && paddr == OFS_CONFIG) begin
         fifo_threshold <= pwdata[3:0];
         fifo_enable_n <= pwdata[CFG_FIFO_N];
         poll_disable <= pwdata[CFG_POLL_OFF];
         lock <= pwdata[CFG_LOCK];
         precomp_start_track <= pwdata[15:8];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         perp_bits <= 4'h0;
      end else if (wr_ok && paddr == OFS_PERP && pwdata[PERP_OW]) begin
         perp_bits <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_on <= 1'b0;
         fifo_threshold_out <= FIFO_THR_RST;
      end else begin
         fifo_on <= ~fifo_enable_n;
         fifo_threshold_out <= fifo_threshold;
      end
   end

   assign sector_bytes = BASE_SECTOR_BYTES << size_code;
   always_comb begin
      pass_bytes = sector_bytes;
      if (size_code == 3'h0) begin
         pass_bytes = (short_sector_length >= BASE_SECTOR_BYTES[7:0]) ?
            BASE_SECTOR_BYTES : {7'h00, short_sector_length};
      end
   end

   assign is_read = op == OP_READ || op == OP_READ_DEL;
   assign is_write = op == OP_WRITE || op == OP_FORMAT;
   assign passing = byte_cnt < pass_bytes;
   assign req = state == S_BYTE && passing && (is_read || is_write);
   assign host_irq = req & mode[MODE_ND];
   assign dma_req = req & ~mode[MODE_ND];
   assign count_mode = op == OP_FORMAT || (op == OP_VERIFY && mode[MODE_EC]);
   assign last_sector = count_mode ? sect_left == 8'h01 : cur_sector == end_sector;

   // Execution engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         op <= OP_READ;
         head_cyl <= 8'h00;
         seek_tgt <= 8'h00;
         cur_sector <= 8'h00;
         cur_head <= 1'b0;
         sect_left <= 8'h00;
         byte_cnt <= 15'h0000;
         step_wait <= 32'h0000_0000;
         present_cylinder <= 8'h00;
         result_status_0 <= 8'h00;
         result_status_1 <= 8'h00;
         result_status_2 <= 8'h00;
         result_status_3 <= 8'h00;
         done <= 1'b0;
      end else if (soft_rst) begin
         state <= S_IDLE;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (go) begin
                  op <= op_e'(pwdata[2:0]);
                  done <= 1'b0;
                  result_status_2 <= 8'h00;
                  step_wait <= 32'(STEP_UNIT * (STEP_UNITS_MAX - int'(step_rate_interval)));
                  cur_sector <= sector_addr;
                  cur_head <= mode[MODE_HEAD];
                  sect_left <= sectors_per_track;
                  state <= S_SECT;
                  if (op_e'(pwdata[2:0]) == OP_SEEK) begin
                     seek_tgt <= target_cylinder;
                     state <= S_STEP;
                  end else if (op_e'(pwdata[2:0]) == OP_REL_SEEK) begin
                     seek_tgt <= rel_dir ? head_cyl + relative_cylinder_offset :
                        head_cyl - relative_cylinder_offset;
                     state <= S_STEP;
                  end else if (op_e'(pwdata[2:0]) == OP_SENSE) begin
                     present_cylinder <= head_cyl;
                     state <= S_DONE;
                  end
               end
            end
            S_STEP: begin
               if (head_cyl == seek_tgt) begin
                  state <= S_DONE;
               end else if (step_wait <= 32'h0000_0001) begin
                  step_wait <= 32'(STEP_UNIT * (STEP_UNITS_MAX - int'(step_rate_interval)));
                  head_cyl <= (seek_tgt > head_cyl) ? head_cyl + 8'h01 : head_cyl - 8'h01;
               end else begin
                  step_wait <= step_wait - 32'h0000_0001;
               end
            end
            S_SECT: begin
               byte_cnt <= 15'h0000;
               if (mode[MODE_SKIP] && ((op == OP_READ && deleted_mark) ||
                   (op == OP_READ_DEL && !deleted_mark))) begin
                  state <= S_NEXT;
               end else begin
                  result_status_2[6] <= result_status_2[6] | (is_read & deleted_mark);
                  state <= S_BYTE;
               end
            end
            S_BYTE: begin
               if (!req || xfer_ack) begin
                  // Excess bytes beyond the passed length run without requests
                  if (byte_cnt == sector_bytes - 15'h0001) begin
                     state <= S_NEXT;
                  end else begin
                     byte_cnt <= byte_cnt + 15'h0001;
                  end
               end
            end
            S_NEXT: begin
               state <= S_SECT;
               if (!last_sector) begin
                  cur_sector <= cur_sector + 8'h01;
                  sect_left <= sect_left - 8'h01;
               end else if (mode[MODE_MT] && !cur_head && !count_mode) begin
                  cur_head <= 1'b1;
                  cur_sector <= 8'h01;
               end else begin
                  state <= S_DONE;
               end
            end
            S_DONE: begin
               result_status_0 <= {2'b00, op == OP_SEEK || op == OP_REL_SEEK,
                  2'b00, cur_head, 2'b00};
               result_status_1 <= 8'h00;
               result_status_3 <= {3'b001, head_cyl == 8'h00, 1'b0, cur_head, 2'b00};
               done <= 1'b1;
               state <= S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // Data paths
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_rd_data <= 8'h00;
         disk_wr_data <= 8'h00;
      end else if (state == S_BYTE) begin
         if (req && xfer_ack && is_read) begin
            host_rd_data <= disk_rd_data;
         end
         if (is_write) begin
            disk_wr_data <= (passing && xfer_ack) ? host_wr_data : 8'h00;
         end
      end
   end

   // Drive pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive <= '0;
      end else begin
         drive.step_pulse <= state == S_STEP && head_cyl != seek_tgt &&
            step_wait <= 32'h0000_0001;
         drive.step_dir <= seek_tgt > head_cyl;
         drive.write_enable <= is_write && (state == S_BYTE ||
            (perp_bits[PERP_WRITE_GATE_TIMING] && state == S_SECT));
         drive.precomp_on <= is_write && state == S_BYTE &&
            head_cyl >= precomp_start_track;
         drive.encode_mfm <= mode[MODE_DD];
         drive.head_sel <= cur_head;
      end
   end

   // Drive polling while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         poll_cnt <= 32'h0000_0000;
         poll_strobe <= 1'b0;
      end else begin
         poll_strobe <= 1'b0;
         if (poll_disable || busy) begin
            poll_cnt <= 32'h0000_0000;
         end else if (poll_cnt >= 32'(POLL_PERIOD - 1)) begin
            poll_cnt <= 32'h0000_0000;
            poll_strobe <= 1'b1;
         end else begin
            poll_cnt <= poll_cnt + 32'h0000_0001;
         end
      end
   end

   always_comb begin
      read_word = 32'h0000_0000;
      unique case (paddr)
         OFS_MODE: read_word = {25'h000_0000, mode};
         OFS_SECTOR: read_word = {short_sector_length, end_sector, 5'h00, size_code,
            sector_addr};
         OFS_TRACK: read_word = {sectors_per_track, 7'h00, rel_dir,
            relative_cylinder_offset, target_cylinder};
         OFS_CONFIG: read_word = {16'h0000, precomp_start_track, 1'b0, lock,
            poll_disable, fifo_enable_n, fifo_threshold};
         OFS_SPECIFY: read_word = {28'h000_0000, step_rate_interval};
         OFS_PERP: read_word = {28'h000_0000, perp_bits};
         OFS_COMMAND: read_word = {28'h000_0000, busy, op};
         OFS_STATUS: read_word = {head_cyl, cur_sector, present_cylinder,
            5'h00, cur_head, done, busy};
         OFS_RESULT: read_word = {result_status_3, result_status_2,
            result_status_1, result_status_0};
         OFS_LENGTH: read_word = {1'b0, pass_bytes, 1'b0, sector_bytes};
         default: read_word = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= read_word;
      end
   end
endmodule : floppy_command_parameter_decode
`default_nettype wire

// ===== bench/fdc_far_side.sv
// Host and drive stand-in for the parameter decoder's byte handshake.
// Acknowledges each byte request after a programmable delay.
`timescale 1ns/100ps
`default_nettype none
module fdc_far_side (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic host_irq,
   input wire logic dma_req,
   input wire logic del_mark,
   input wire logic [7:0] delay,
   output logic xfer_ack,
   output logic sector_deleted,
   output logic [7:0] disk_rd_data,
   output logic [7:0] host_wr_data,
   output logic [31:0] irq_acks,
   output logic [31:0] dma_acks
);
   logic [7:0] wait_n;
   logic [7:0] seq;
   assign sector_deleted = del_mark;
   // Bytes are valid only with the acknowledge; otherwise the lines flip
   assign disk_rd_data = xfer_ack ? seq : ~seq;
   assign host_wr_data = xfer_ack ? seq : ~seq;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer_ack <= 1'b0;
         wait_n <= 8'h00;
         seq <= 8'h00;
         irq_acks <= 32'h0000_0000;
         dma_acks <= 32'h0000_0000;
      end else if (xfer_ack) begin
         xfer_ack <= 1'b0;
         wait_n <= 8'h00;
         seq <= seq + 8'h01;
      end else if ((host_irq || dma_req) && wait_n >= delay) begin
         xfer_ack <= 1'b1;
         irq_acks <= irq_acks + 32'(host_irq);
         dma_acks <= dma_acks + 32'(dma_req);
      end else if (host_irq || dma_req) begin
         wait_n <= wait_n + 8'h01;
      end
   end
endmodule : fdc_far_side
`default_nettype wire

// ===== bench/floppy_command_parameter_decode_checker.sv
// Port-level assertions for the parameter decoder.
// Bound into every decoder instance; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module fdc_checker #(
   parameter int STEP_UNIT = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic xfer_ack,
   input wire logic host_irq,
   input wire logic dma_req,
   input wire fdc_param_pkg::drive_s drive,
   input wire logic fifo_on,
   input wire logic [3:0] fifo_threshold_out,
   input wire logic poll_strobe
);
   import fdc_param_pkg::*;
   int gap;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gap <= 1000;
      else if (drive.step_pulse) gap <= 0;
      else if (gap < 1000) gap <= gap + 1;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_high_a: assert property (pready) else $error("pready low");
   err_phase_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
   size_refuse_a: assert property (psel && penable && pwrite && paddr == OFS_SECTOR
      && pwdata[15:8] > MAX_SIZE_CODE |-> pslverr) else $error("size code taken");
   req_excl_a: assert property (!(host_irq && dma_req)) else $error("both requests");
   irq_hold_a: assert property (host_irq && !xfer_ack |=> host_irq) else $error("irq dropped");
   dma_hold_a: assert property (dma_req && !xfer_ack |=> dma_req) else $error("dma dropped");
   step_gap_a: assert property (drive.step_pulse |-> gap >= STEP_UNIT - 1)
      else $error("steps too close");
   step_once_a: assert property (drive.step_pulse |=> !drive.step_pulse)
      else $error("step pulse long");
   poll_idle_a: assert property (poll_strobe |-> !host_irq && !dma_req)
      else $error("poll while busy");
   fifo_cfg_a: assert property (psel && penable && pwrite && !pslverr && paddr == OFS_CONFIG
      |=> ##1 fifo_on == !$past(pwdata[4], 2) && fifo_threshold_out == $past(pwdata[3:0], 2))
      else $error("fifo config not applied");
   cover property (host_irq && xfer_ack);
   cover property (dma_req && xfer_ack);
   cover property (drive.step_pulse);
endmodule : fdc_checker
bind floppy_command_parameter_decode fdc_checker #(.STEP_UNIT(STEP_UNIT)) u_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .xfer_ack,
   .host_irq, .dma_req, .drive, .fifo_on, .fifo_threshold_out, .poll_strobe);
`default_nettype wire

// ===== bench/floppy_command_parameter_decode_test.sv
// Self-checking bench for the parameter decoder over APB.
// Uses fdc_far_side as byte partner; short step and poll counts.
`timescale 1ns/100ps
`default_nettype none
module floppy_command_parameter_decode_test;
   import fdc_param_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
   logic sector_deleted, xfer_ack, host_irq, dma_req, fifo_on, poll_strobe, del_mark;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata, irq_acks, dma_acks, i0, d0;
   logic [31:0] steps, polls, cyc, slast, sgap, p0;
   logic [7:0] disk_rd_data, host_wr_data, host_rd_data, disk_wr_data, delay;
   logic [3:0] fifo_threshold_out;
   drive_s drive;
   int n_fail, tests_run;
   floppy_command_parameter_decode #(.STEP_UNIT(4), .POLL_PERIOD(8)) dut (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sector_deleted,
      .xfer_ack, .disk_rd_data, .host_wr_data, .host_irq, .dma_req, .host_rd_data,
      .disk_wr_data, .drive, .fifo_on, .fifo_threshold_out, .poll_strobe);
   fdc_far_side far (.pclk, .presetn, .host_irq, .dma_req, .del_mark, .delay, .xfer_ack,
      .sector_deleted, .disk_rd_data, .host_wr_data, .irq_acks, .dma_acks);
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (poll_strobe === 1'b1) polls <= polls + 1;
      if (drive.step_pulse === 1'b1) begin
         steps <= steps + 1;
         sgap <= cyc - slast;
         slast <= cyc;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Answer is settled before the completing edge
      do @(negedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      serr = pslverr;
      @(posedge pclk);
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic go(input logic [2:0] op);
      i0 = irq_acks;
      d0 = dma_acks;
      apb(1'b1, OFS_COMMAND, {29'h0000_0001, op});
   endtask : go
   task automatic fin(input logic [31:0] ei, input logic [31:0] ed);
      int n;
      n = 0;
      do begin
         apb(1'b0, OFS_STATUS, '0);
         n++;
      end while (rdata[1:0] !== 2'b10 && n < 5000);
      chk(32'(n < 5000), 32'h1);
      chk(irq_acks - i0, ei);
      chk(dma_acks - d0, ed);
   endtask : fin
   task automatic t_regs;
      logic [31:0] sb;
      apb(1'b0, OFS_SECTOR, '0);
      chk(rdata, 32'hff01_0201);
      apb(1'b0, OFS_CONFIG, '0);
      chk(rdata, 32'h10);
      apb(1'b0, 12'h030, '0);
      chk(32'(serr), 32'h1);
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, OFS_SECTOR, {16'h0501, 5'h00, c[2:0], 8'h01});
         apb(1'b0, OFS_LENGTH, '0);
         sb = 32'h80 << c;
         chk(rdata, {1'b0, (c == 0) ? 15'h0005 : sb[14:0], 1'b0, sb[14:0]});
      end
      apb(1'b1, OFS_SECTOR, 32'h0001_0801);
      chk(32'(serr), 32'h1);
   endtask : t_regs
   task automatic t_xfer;
      int n;
      apb(1'b1, OFS_SECTOR, 32'h0201_0001);
      for (int m = 0; m < 2; m++) begin
         delay = 8'd20;
         apb(1'b1, OFS_MODE, 32'(9 * m));
         go(OP_READ);
         repeat (4) @(posedge pclk);
         chk(32'(drive.encode_mfm), m);
         apb(1'b1, OFS_MODE, 32'h2);
         chk(32'(serr), 32'h1);
         fin(m ? 2 : 0, m ? 0 : 2);
      end
      delay = 8'd0;
      for (int g = 0; g < 2; g++) begin
         apb(1'b1, OFS_PERP, g ? 32'h0000_0082 : 32'h0000_0080);
         apb(1'b0, OFS_PERP, '0);
         chk(rdata, 32'(2 * g));
         apb(1'b1, OFS_PERP, '0);
         apb(1'b0, OFS_PERP, '0);
         chk(rdata, 32'(2 * g));
         apb(1'b1, OFS_MODE, '0);
         delay = 8'd20;
         go(OP_WRITE);
         n = 0;
         while (dma_req !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
         end
         chk(32'(drive.write_enable), g);
         fin(0, 2);
         delay = 8'd0;
      end
   endtask : t_xfer
   task automatic sk(input logic [31:0] md, input logic [2:0] op, input logic dm,
      input logic [31:0] ed);
      del_mark = dm;
      apb(1'b1, OFS_MODE, md);
      go(op);
      fin(0, ed);
   endtask : sk
   task automatic t_seek(input logic [31:0] trk, input logic [2:0] op, input logic [31:0] ns);
      p0 = steps;
      apb(1'b1, OFS_TRACK, trk);
      go(op);
      fin(0, 0);
      chk(steps - p0, ns);
   endtask : t_seek
   task automatic t_cfg(input logic [31:0] cfg, input logic [31:0] after);
      apb(1'b1, OFS_CONFIG, cfg);
      repeat (2) @(posedge pclk);
      chk({27'h000_0000, fifo_on, fifo_threshold_out}, 32'h15);
      apb(1'b1, OFS_COMMAND, 32'h100);
      apb(1'b0, OFS_CONFIG, '0);
      chk(rdata, after);
   endtask : t_cfg
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   initial begin
      {psel, penable, pwrite, presetn, del_mark} = 5'h00;
      {paddr, pwdata, delay} = '0;
      {n_fail, tests_run} = '0;
      {steps, polls, cyc, slast, sgap} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_xfer;
      apb(1'b1, OFS_SECTOR, 32'h0103_0002);
      sk(32'h2, OP_READ, 1'b0, 5);
      apb(1'b0, OFS_STATUS, '0);
      chk(32'(rdata[2]), 32'h1);
      sk(32'h0, OP_READ, 1'b0, 2);
      sk(32'h4, OP_READ, 1'b1, 0);
      sk(32'h4, OP_READ_DEL, 1'b1, 2);
      sk(32'h4, OP_READ_DEL, 1'b0, 0);
      sk(32'h0, OP_READ, 1'b1, 2);
      apb(1'b1, OFS_TRACK, 32'h0200_0000);
      sk(32'h0, OP_FORMAT, 1'b0, 2);
      sk(32'h10, OP_VERIFY, 1'b0, 0);
      apb(1'b1, OFS_SPECIFY, 32'hf);
      t_seek(32'h0100_0003, OP_SEEK, 3);
      chk(sgap, 32'h4);
      t_seek(32'h0100_0003, OP_SENSE, 0);
      chk(32'(rdata[15:8]), 32'h3);
      t_seek(32'h0100_0200, OP_REL_SEEK, 2);
      chk(32'(rdata[31:24]), 32'h1);
      t_seek(32'h0101_0400, OP_REL_SEEK, 4);
      chk(32'(rdata[31:24]), 32'h5);
      apb(1'b1, OFS_SPECIFY, '0);
      t_seek(32'h0100_0007, OP_SEEK, 2);
      chk(sgap, 32'h40);
      t_cfg(32'hff05, 32'h10);
      t_cfg(32'hff45, 32'hff45);
      for (int d = 0; d < 2; d++) begin
         apb(1'b1, OFS_CONFIG, d ? 32'h30 : 32'h10);
         repeat (2) @(posedge pclk);
         p0 = polls;
         repeat (40) @(posedge pclk);
         chk(32'(polls != p0), d ? 0 : 1);
      end
      final_report;
   end
   initial begin
      #400_000;
      n_fail++;
      final_report;
   end
endmodule : floppy_command_parameter_decode_test
`default_nettype wire
